// ==== bgt_boot_guard_timer.sv ====
// The APB register port and the register offsets were left to the implementer.
`default_nettype none

// How it works
// - clear on controller reset, count once running
// - eleven-bit up-counter with carry and controls
// - timebase ticks give carry after 62.5 ms
// - carry stops counter, flags overflow, blinks led
// - reset or test without disable: initialize
// - all controls low: count each timebase tick
// - disable, carry, reset or test end counting
// - disable stops counter until cleared or power-on
// - led active low, 125 ms on per second
// - only reset or test stop the blinking
// - overflow flag cleared by one or power-on
// - timer register bits, address, zero reset value
module bgt_boot_guard_timer
  import bgt_pkg::*;
#(
  parameter int unsigned CNT_W              = BGT_CNT_W,
  parameter int unsigned BLINK_PERIOD_TICKS = BGT_BLINK_PERIOD_TICKS,
  parameter int unsigned BLINK_ON_TICKS     = BGT_BLINK_ON_TICKS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rtc_timebase,
  input  wire logic        controller_core_reset,
  input  wire logic        ate_program_pin,
  output logic             fault_led_n,
  output logic             irq
);

  // ===========================================================
  // elaboration checks
  generate
    if (CNT_W < 2 || CNT_W > 30) begin : g_bad_cnt
      $error("boot guard counter width out of range");
    end
    if (CNT_W == BGT_CNT_W && (1 << CNT_W) != BGT_GUARD_TICKS)
    begin : g_bad_guard
      $error("guard time does not match the counter span");
    end
  endgenerate

  // ===========================================================
  // pin synchronisation
  bgt_pins_t pins_async;
  bgt_pins_t pins_sync;
  logic      tb_prev_reg;
  logic      tick;

  assign pins_async = '{core_reset:  controller_core_reset,
                        program_pin: ate_program_pin,
                        timebase:    rtc_timebase};

  // pins come from other domains, so two flops before use
  bgt_sync #(
    .WIDTH    ($bits(bgt_pins_t))
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // rising edge of the timebase becomes a one-cycle tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_prev_reg <= 1'b0;
    end else begin
      tb_prev_reg <= pins_sync.timebase;
    end
  end

  assign tick = pins_sync.timebase && !tb_prev_reg;

  // ===========================================================
  // timer register and interrupt registers
  bgt_ctrl_t               ctrl_reg;
  logic                    ovf_flag_reg;
  logic [BGT_IRQ_W-1:0]    irq_stat_reg;
  logic [BGT_IRQ_W-1:0]    irq_mask_reg;
  logic                    pready_reg;
  logic [31:0]             prdata_reg;
  logic                    pslverr_reg;
  logic                    irq_reg;

  // address decode, shared by the read mux and the write strobes
  logic                    hit_timer;
  logic                    hit_stat;
  logic                    hit_mask;
  logic                    hit_any;
  logic                    acc_first;
  logic                    wr_commit;
  logic                    wr_timer;
  logic                    wr_stat;
  logic                    wr_mask;
  logic [31:0]             rd_word;
  logic [7:0]              timer_view;

  assign hit_timer = (paddr == BGT_TIMER_ADDR);
  assign hit_stat  = (paddr == BGT_IRQ_STAT_ADDR);
  assign hit_mask  = (paddr == BGT_IRQ_MASK_ADDR);
  assign hit_any   = hit_timer || hit_stat || hit_mask;

  // one wait state: ready rises in the second access cycle, and a
  // write lands only on the edge that samples ready high
  assign acc_first = psel && penable && !pready_reg;
  assign wr_commit = psel && penable && pready_reg && pwrite;
  assign wr_timer  = wr_commit && hit_timer;
  assign wr_stat   = wr_commit && hit_stat;
  assign wr_mask   = wr_commit && hit_mask;

  // timer register view: overflow, test, disable, rest reads zero
  assign timer_view = {5'h00, ovf_flag_reg, ctrl_reg.test,
                       ctrl_reg.halt};

  assign rd_word = hit_timer ? {24'h000000, timer_view} :
                   hit_stat  ? {30'h00000000, irq_stat_reg} :
                   hit_mask  ? {30'h00000000, irq_mask_reg} :
                   32'h0000_0000;

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= acc_first;
      prdata_reg  <= (acc_first && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr_reg <= acc_first && !hit_any;
    end
  end

  // control bits: software writes, power-on reset clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '{test: BGT_TIMER_RESET[BGT_TEST_BIT],
                    halt: BGT_TIMER_RESET[BGT_DIS_BIT]};
    end else if (wr_timer) begin
      ctrl_reg <= '{test: pwdata[BGT_TEST_BIT],
                    halt: pwdata[BGT_DIS_BIT]};
    end
  end

  // ===========================================================
  // guard state machine
  bgt_state_t           state_reg;
  bgt_state_t           state_next;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     cnt_next;
  logic                 hold;
  logic                 wrap;
  logic                 cnt_adv;

  // controller held in reset, by its own reset or the program pin,
  // or the test bit set
  assign hold = pins_sync.core_reset || pins_sync.program_pin ||
                ctrl_reg.test;

  // carry is the wrap of the counter on a tick while counting
  assign wrap = (state_reg == BGT_ST_COUNT) && tick &&
                (cnt_reg == {CNT_W{1'b1}});

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BGT_ST_OVF: begin
        // disable alone cannot end the blinking
        if (hold) begin
          state_next = ctrl_reg.halt ? BGT_ST_DIS
                                        : BGT_ST_INIT;
        end else begin
          state_next = BGT_ST_OVF;
        end
      end
      BGT_ST_COUNT: begin
        if (ctrl_reg.halt) begin
          state_next = BGT_ST_DIS;
        end else if (hold) begin
          state_next = BGT_ST_INIT;
        end else if (wrap) begin
          state_next = BGT_ST_OVF;
        end else begin
          state_next = BGT_ST_COUNT;
        end
      end
      BGT_ST_INIT, BGT_ST_DIS: begin
        if (ctrl_reg.halt) begin
          state_next = BGT_ST_DIS;
        end else if (hold) begin
          state_next = BGT_ST_INIT;
        end else begin
          state_next = BGT_ST_COUNT;
        end
      end
      default: begin
        state_next = BGT_ST_INIT;
      end
    endcase
  end

  // counter advances only while counting and staying in counting;
  // disabled keeps its value so counting resumes where it stopped
  assign cnt_adv  = (state_reg == BGT_ST_COUNT) &&
                    (state_next == BGT_ST_COUNT) && tick;
  assign cnt_next = (state_next == BGT_ST_INIT) ? '0 :
                    wrap    ? '0 :
                    cnt_adv ? cnt_reg + CNT_W'(1) :
                    cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= BGT_ST_INIT;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ===========================================================
  // overflow flag, write one to clear; a new carry wins the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_reg <= BGT_TIMER_RESET[BGT_OVF_BIT];
    end else if (wrap) begin
      ovf_flag_reg <= 1'b1;
    end else if (wr_timer && pwdata[BGT_OVF_BIT]) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  // ===========================================================
  // interrupt status and mask; set wins over a same-cycle clear
  logic [BGT_IRQ_W-1:0] irq_events;

  assign irq_events[BGT_IRQ_OVF_BIT] = wrap;
  assign irq_events[BGT_IRQ_DIS_BIT] = (state_reg == BGT_ST_COUNT) &&
                                       (state_next == BGT_ST_DIS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= BGT_IRQ_RESET;
      irq_mask_reg <= BGT_IRQ_RESET;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_events |
                      (irq_stat_reg &
                       ~(wr_stat ? pwdata[BGT_IRQ_W-1:0] : BGT_IRQ_RESET));
      irq_mask_reg <= wr_mask ? pwdata[BGT_IRQ_W-1:0] : irq_mask_reg;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ===========================================================
  // fault led: blink phase only while in overflow
  logic led_on;

  bgt_blink #(
    .PERIOD_TICKS (BLINK_PERIOD_TICKS),
    .ON_TICKS     (BLINK_ON_TICKS)
  ) u_blink (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (tick),
    .run          (state_reg == BGT_ST_OVF),
    .led_on       (led_on)
  );

  // led is dark from reset; pin low means lit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_led_n <= 1'b1;
    end else begin
      fault_led_n <= !led_on;
    end
  end

  // ===========================================================
  // outputs straight from flops
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

endmodule : bgt_boot_guard_timer

`default_nettype wire

// ==== bgt_pkg.sv ====
`default_nettype none

package bgt_pkg;

  // ===========================================================
  // register map
  // the timer register index is not word aligned, so it is kept
  // as an index and the byte address is four times it
  localparam logic [15:0] BGT_TIMER_IDX      = 16'h7f86;
  localparam logic [31:0] BGT_TIMER_ADDR     = {14'h0000, BGT_TIMER_IDX,
                                                2'b00};
  localparam logic [31:0] BGT_IRQ_STAT_ADDR  = 32'h0000_0000;
  localparam logic [31:0] BGT_IRQ_MASK_ADDR  = 32'h0000_0004;

  // ===========================================================
  // field layout and reset values
  localparam int unsigned BGT_DIS_BIT        = 0;
  localparam int unsigned BGT_TEST_BIT       = 1;
  localparam int unsigned BGT_OVF_BIT        = 2;
  localparam logic [7:0]  BGT_TIMER_RESET    = 8'h00;
  localparam int unsigned BGT_IRQ_W          = 2;
  localparam int unsigned BGT_IRQ_OVF_BIT    = 0;
  localparam int unsigned BGT_IRQ_DIS_BIT    = 1;
  localparam logic [1:0]  BGT_IRQ_RESET      = 2'h0;

  // ===========================================================
  // timing, in timebase ticks derived from times as printed
  localparam int unsigned BGT_TB_HZ          = 32768;
  localparam int unsigned BGT_PCLK_HZ        = 25000000;
  localparam int unsigned BGT_GUARD_US       = 62500;
  localparam int unsigned BGT_BLINK_PERIOD_MS = 1000;
  localparam int unsigned BGT_BLINK_ON_MS    = 125;
  localparam int unsigned BGT_CNT_W          = 11;
  // product stays below 2**32, so unsigned arithmetic is exact
  localparam int unsigned BGT_GUARD_TICKS    =
    BGT_TB_HZ * BGT_GUARD_US / 1000000;
  localparam int unsigned BGT_BLINK_PERIOD_TICKS =
    BGT_TB_HZ * BGT_BLINK_PERIOD_MS / 1000;
  localparam int unsigned BGT_BLINK_ON_TICKS =
    BGT_TB_HZ * BGT_BLINK_ON_MS / 1000;

  // ===========================================================
  // states and carriers
  typedef enum logic [3:0] {
    BGT_ST_INIT  = 4'b0001,
    BGT_ST_COUNT = 4'b0010,
    BGT_ST_OVF   = 4'b0100,
    BGT_ST_DIS   = 4'b1000
  } bgt_state_t;

  typedef struct packed {
    logic test;
    logic halt;
  } bgt_ctrl_t;

  typedef struct packed {
    logic core_reset;
    logic program_pin;
    logic timebase;
  } bgt_pins_t;

endpackage : bgt_pkg

`default_nettype wire

// ==== bgt_sync.sv ====
`default_nettype none

// ===========================================================
// two-flop synchroniser for asynchronous pins
module bgt_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("bgt_sync width must be at least one");
    end
  endgenerate

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : bgt_sync

`default_nettype wire

// ==== bgt_blink.sv ====
`default_nettype none

// ===========================================================
// blink phase generator, counts timebase ticks while run is high
module bgt_blink
  import bgt_pkg::*;
#(
  parameter int unsigned PERIOD_TICKS = BGT_BLINK_PERIOD_TICKS,
  parameter int unsigned ON_TICKS     = BGT_BLINK_ON_TICKS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick,
  input  wire logic run,
  output logic      led_on
);

  localparam int unsigned PW = $clog2(PERIOD_TICKS);
  localparam logic [PW-1:0] LAST = PW'(PERIOD_TICKS - 1);
  localparam logic [PW-1:0] ON_LIM = PW'(ON_TICKS);

  logic [PW-1:0] phase_reg;
  logic [PW-1:0] phase_next;

  generate
    if (PERIOD_TICKS < 2 || ON_TICKS < 1 || ON_TICKS >= PERIOD_TICKS)
    begin : g_bad_blink
      $error("bgt_blink on time must lie inside the period");
    end
  endgenerate

  // phase restarts when run drops, so each blink run opens with an on time
  assign phase_next = !run ? '0 :
                      !tick ? phase_reg :
                      (phase_reg == LAST) ? '0 :
                      phase_reg + PW'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= '0;
      led_on    <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      led_on    <= run && (phase_reg < ON_LIM);
    end
  end

endmodule : bgt_blink

`default_nettype wire

// ==== bgt_timer_sva.sv ====
`default_nettype none

// ===========================================================
// port-level checks for the boot guard timer
module bgt_timer_sva
  import bgt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rtc_timebase,
  input wire logic        controller_core_reset,
  input wire logic        ate_program_pin,
  input wire logic        fault_led_n,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // decode of the three mapped words
  wire logic mapped = (paddr == BGT_TIMER_ADDR) ||
                      (paddr == BGT_IRQ_STAT_ADDR) ||
                      (paddr == BGT_IRQ_MASK_ADDR);

  // ===========================================================
  // steps of bus and pin behaviour
  sequence s_access;
    psel && penable && !pready;
  endsequence
  // eight cycles covers sync, state update and blink lag
  sequence s_hold_core;
    controller_core_reset [*8];
  endsequence
  sequence s_hold_pgm;
    ate_program_pin [*8];
  endsequence

  chk_ready_next: assert property (s_access |=> pready)
    else $error("ready missing after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside ready");
  chk_rdata_resv: assert property (pready && !pwrite |->
    prdata[31:3] == '0) else $error("reserved bits not zero");
  chk_unmapped_err: assert property (pready |->
    pslverr == !mapped) else $error("error flag wrong for address");
  chk_led_core: assert property (s_hold_core |-> fault_led_n)
    else $error("led lit while core held");
  chk_led_pgm: assert property (s_hold_pgm |-> fault_led_n)
    else $error("led lit while programming");
endmodule : bgt_timer_sva

bind bgt_boot_guard_timer bgt_timer_sva u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .rtc_timebase, .controller_core_reset,
  .ate_program_pin, .fault_led_n, .irq
);

`default_nettype wire

// ==== bgt_fw_model.sv ====
`default_nettype none

// ===========================================================
// microcontroller side: core reset line and timebase source
module bgt_fw_model #(
  parameter int unsigned HALF = 10
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hold_core,
  output logic      rtc_timebase,
  output logic      controller_core_reset
);
  timeunit 1ns;
  timeprecision 1ns;

  int unsigned cnt;

  // timebase runs free, sped up so a guard period fits a short run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt          <= 0;
      rtc_timebase <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt          <= 0;
      rtc_timebase <= ~rtc_timebase;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // core stays in reset through power-on and while the bench holds it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_core_reset <= 1'b1;
    end else begin
      controller_core_reset <= hold_core;
    end
  end
endmodule : bgt_fw_model

`default_nettype wire

// ==== test_boot_guard_timer.sv ====
`default_nettype none

module test_boot_guard_timer
  import bgt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TICK = 20;
  logic        pclk            = 1'b0;
  logic        presetn         = 1'b0;
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [31:0] paddr           = '0;
  logic [31:0] pwdata          = '0;
  logic        ate_program_pin = 1'b0;
  logic        hold_core       = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, rtc_timebase, core_rst, fault_led_n, irq;
  int          bad_count       = 0;
  int          n_checks        = 0;

  always #20 pclk = ~pclk;

  // small counts keep the run short: carry after 8 ticks
  bgt_boot_guard_timer #(.CNT_W(3), .BLINK_PERIOD_TICKS(8),
    .BLINK_ON_TICKS(2)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rtc_timebase,
    .controller_core_reset(core_rst), .ate_program_pin,
    .fault_led_n, .irq);

  bgt_fw_model #(.HALF(TICK / 2)) u_fw (.pclk, .presetn, .hold_core,
    .rtc_timebase, .controller_core_reset(core_rst));

  // ===========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, '0, r, e);
    chk(r, x);
  endtask : rdchk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic wt(input int t);
    repeat (t * TICK) @(posedge pclk);
  endtask : wt

  // skip a partial low phase, then time one full low and high phase
  task automatic led_meas(output int lo, output int hi);
    int n;
    n = 0;
    lo = 0;
    hi = 0;
    while (fault_led_n === 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    while (fault_led_n !== 1'b0 && n < 800) begin
      @(posedge pclk);
      n++;
    end
    while (fault_led_n === 1'b0 && lo < 400) begin
      @(posedge pclk);
      lo++;
    end
    while (fault_led_n === 1'b1 && hi < 400) begin
      @(posedge pclk);
      hi++;
    end
  endtask : led_meas

  // ===========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rdchk(BGT_TIMER_ADDR, 32'h0);
    rdchk(BGT_IRQ_STAT_ADDR, 32'h0);
    rdchk(BGT_IRQ_MASK_ADDR, 32'h0);
    wr(BGT_IRQ_MASK_ADDR, 32'h3);
    rdchk(BGT_IRQ_MASK_ADDR, 32'h3);
    wr(BGT_TIMER_ADDR, 32'hffff_fff8);
    rdchk(BGT_TIMER_ADDR, 32'h0);
    apb(1'b0, 32'h0000_0100, '0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask : t_regs

  task automatic t_overflow;
    int lo, hi, n;
    hold_core <= 1'b1;
    repeat (10) @(posedge pclk);
    hold_core <= 1'b0;
    wt(6);
    rdchk(BGT_TIMER_ADDR, 32'h0);
    wt(4);
    rdchk(BGT_TIMER_ADDR, 32'h4);
    rdchk(BGT_IRQ_STAT_ADDR, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(BGT_IRQ_MASK_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(BGT_IRQ_MASK_ADDR, 32'h1);
    led_meas(lo, hi);
    chk(32'(lo >= 39 && lo <= 41), 32'h1);
    chk(32'(hi >= 119 && hi <= 121), 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(BGT_TIMER_ADDR, 32'h1);
    led_meas(lo, hi);
    chk(32'(lo >= 39 && lo <= 41), 32'h1);
    wr(BGT_TIMER_ADDR, 32'h2);
    repeat (8) @(posedge pclk);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      if (fault_led_n !== 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    rdchk(BGT_TIMER_ADDR, 32'h6);
    wr(BGT_TIMER_ADDR, 32'h6);
    rdchk(BGT_TIMER_ADDR, 32'h2);
    wr(BGT_IRQ_STAT_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_overflow

  task automatic t_disable;
    wr(BGT_TIMER_ADDR, 32'h0);
    wt(4);
    wr(BGT_TIMER_ADDR, 32'h1);
    hold_core <= 1'b1;
    ate_program_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    hold_core <= 1'b0;
    ate_program_pin <= 1'b0;
    wt(12);
    rdchk(BGT_TIMER_ADDR, 32'h1);
    wr(BGT_TIMER_ADDR, 32'h0);
    wt(6);
    rdchk(BGT_TIMER_ADDR, 32'h4);
    rdchk(BGT_IRQ_STAT_ADDR, 32'h3);
    wr(BGT_IRQ_STAT_ADDR, 32'h3);
    rdchk(BGT_IRQ_STAT_ADDR, 32'h0);
  endtask : t_disable

  task automatic t_program;
    wr(BGT_TIMER_ADDR, 32'h6);
    wr(BGT_TIMER_ADDR, 32'h0);
    wt(5);
    ate_program_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    ate_program_pin <= 1'b0;
    wt(6);
    rdchk(BGT_TIMER_ADDR, 32'h0);
    wt(4);
    rdchk(BGT_TIMER_ADDR, 32'h4);
  endtask : t_program

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // ===========================================================
  // main sequence and hang guard
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_overflow();
    t_disable();
    t_program();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    summarize();
  end
endmodule : test_boot_guard_timer

`default_nettype wire
